/* File: logic/mic_irq_ctrl.v */
// Interrupt controller: flags, enables, priority, vectoring and stack
//
// The address map and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
`include "mic_defines.vh"

// Functional notes
// - Edge field: off, rising, falling, both
// - Flags set even when source disabled
// - Global enable clear blocks every vector
// - Take: push next PC, load vector
// - Return pops saved PC back
// - Each source has distinct vector
// - Taking interrupt clears global enable
// - Flags keep latching while blocked
// - No acknowledge while stack full
// - Any set flag wakes from sleep
// - Primary register bit layout
// - Secondary register bit layout
// - Edge register upper bits read zero
// - Servicing clears that source flag
// - Serial service clears only its flag
module mic_irq_ctrl (
    input  wire        clock,
    input  wire        nrst,
    input  wire [3:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest,
    input  wire        ext_pin,
    input  wire        conv_event,
    input  wire        cmp_p_event,
    input  wire        cmp_a_event,
    input  wire        serial_event,
    input  wire        tick0_event,
    input  wire        tick1_event,
    input  wire        instr_boundary,
    input  wire [11:0] next_pc,
    input  wire        return_from_irq,
    input  wire        push_call,
    output reg         pc_load,
    output reg  [11:0] pc_value,
    output wire        wake,
    output wire        stack_full,
    output wire        irq
);

    // Reset synchroniser
    reg        rst_meta;
    reg        rst_n;
    // External pin synchroniser and edge history
    reg        pin_meta;
    reg        pin_sync;
    reg        pin_last;
    // Software registers
    reg [1:0]  ext_edge_select_field;
    reg        global_irq_enable;
    reg [6:0]  irq_enable;
    reg [6:0]  irq_flag;
    reg [6:0]  next_irq_flag;  // Flags after write, service and events
    reg [6:0]  evt_status;
    reg [6:0]  evt_enable;
    // Stack pointer and controller state
    reg [3:0]  sp;
    reg        state;
    reg [2:0]  taken_src;
    reg        ack;
    reg        rd_pend;

    // Source grouping in priority order
    wire [6:0] src_event;
    wire [6:0] pending;
    wire       rise;
    wire       fall;
    reg        ext_event;
    wire       take;
    wire [11:0] stk_rd;
    wire       push;
    wire       pop;
    wire       wr;

    // Register write decode
    assign wr   = avs_write & avs_byteenable[0];

    // One-cycle read latency, writes complete at once
    assign avs_waitrequest = avs_read & ~rd_pend;

    // Lowest set index, priority encoder
    function [2:0] mic_first;
        input [6:0] v;
        integer i;
        begin
            mic_first = 3'h0;
            for (i = 6; i >= 0; i = i - 1) begin
                if (v[i]) begin
                    mic_first = i[2:0];
                end
            end
        end
    endfunction

    // Vector lookup per source
    function [11:0] mic_vector;
        input [2:0] s;
        begin
            case (s)
                3'h0: mic_vector = `MIC_VEC_EXT;
                3'h1: mic_vector = `MIC_VEC_CMPP;
                3'h2: mic_vector = `MIC_VEC_CONV;
                3'h3: mic_vector = `MIC_VEC_CMPA;
                3'h4: mic_vector = `MIC_VEC_SER;
                3'h5: mic_vector = `MIC_VEC_TICK0;
                default: mic_vector = `MIC_VEC_TICK1;
            endcase
        end
    endfunction

    // Reset release through two flops
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Pin passes two flops before the edge detector
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
            pin_last <= 1'b0;
        end else begin
            pin_meta <= ext_pin;
            pin_sync <= pin_meta;
            pin_last <= pin_sync;
        end
    end

    assign rise = pin_sync & ~pin_last;
    assign fall = ~pin_sync & pin_last;

    // Edge selection
    always @* begin
        case (ext_edge_select_field)
            `MIC_EDGE_OFF:  ext_event = 1'b0;
            `MIC_EDGE_RISE: ext_event = rise;
            `MIC_EDGE_FALL: ext_event = fall;
            default:        ext_event = rise | fall;
        endcase
    end

    assign src_event = {tick1_event, tick0_event, serial_event,
                        cmp_a_event, conv_event, cmp_p_event, ext_event};

    // Flags and enables must all agree
    assign pending = irq_flag & irq_enable;
    assign stack_full = (sp == `MIC_SP_FULL);
    assign take = instr_boundary & global_irq_enable & (|pending)
                & ~stack_full & (state == `MIC_ST_RUN);
    assign push = take | (push_call & ~stack_full);
    assign pop  = return_from_irq & (sp != `MIC_SP_ZERO);

    // Wake regardless of any enable
    assign wake = |irq_flag;

    // Controller interrupt line from status and its enables
    assign irq = |(evt_status & evt_enable);

    // Next flag value: one place, so a hardware event always wins
    always @* begin
        next_irq_flag = irq_flag;
        if (wr && avs_address == `MIC_ADDR_CTRL0) begin
            next_irq_flag[`MIC_SRC_EXT]  = avs_writedata[`MIC_C0_EXT_F];
            next_irq_flag[`MIC_SRC_CONV] = avs_writedata[`MIC_C0_CONV_F];
            next_irq_flag[`MIC_SRC_CMPP] = avs_writedata[`MIC_C0_CMPP_F];
        end
        if (wr && avs_address == `MIC_ADDR_CTRL1) begin
            next_irq_flag[`MIC_SRC_CMPA]  = avs_writedata[`MIC_C1_CMPA_F];
            next_irq_flag[`MIC_SRC_SER]   = avs_writedata[`MIC_C1_SER_F];
            next_irq_flag[`MIC_SRC_TICK0] = avs_writedata[`MIC_C1_TICK0_F];
            next_irq_flag[`MIC_SRC_TICK1] = avs_writedata[`MIC_C1_TICK1_F];
        end
        if (take) begin
            next_irq_flag[mic_first(pending)] = 1'b0;
        end
        next_irq_flag = next_irq_flag | src_event;
    end

    // Return stack storage
    mic_stack_mem u_stack (
        .clock   (clock),
        .wr_en   (push),
        .wr_addr (sp[2:0]),
        .wr_data (next_pc),
        .rd_addr (sp[2:0] - 3'h1),
        .rd_data (stk_rd)
    );

    // Registers, flags, stack pointer and vector sequence
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ext_edge_select_field <= 2'h0;
            global_irq_enable     <= 1'b0;
            irq_enable            <= 7'h00;
            irq_flag              <= 7'h00;
            evt_status            <= 7'h00;
            evt_enable            <= 7'h00;
            sp                    <= `MIC_SP_ZERO;
            state                 <= `MIC_ST_RUN;
            taken_src             <= 3'h0;
            ack                   <= 1'b0;
            pc_load               <= 1'b0;
            pc_value              <= 12'h000;
        end else begin
            pc_load <= 1'b0;
            ack     <= 1'b0;
            // Software writes; hardware events applied after, so set wins
            if (wr) begin
                case (avs_address)
                    `MIC_ADDR_EDGE: begin
                        ext_edge_select_field <= avs_writedata[1:0];
                    end
                    `MIC_ADDR_CTRL0: begin
                        global_irq_enable <= avs_writedata[`MIC_C0_GIE];
                        irq_enable[`MIC_SRC_EXT]  <= avs_writedata[`MIC_C0_EXT_EN];
                        irq_enable[`MIC_SRC_CONV] <= avs_writedata[`MIC_C0_CONV_EN];
                        irq_enable[`MIC_SRC_CMPP] <= avs_writedata[`MIC_C0_CMPP_EN];
                    end
                    `MIC_ADDR_CTRL1: begin
                        irq_enable[`MIC_SRC_CMPA]  <= avs_writedata[`MIC_C1_CMPA_EN];
                        irq_enable[`MIC_SRC_SER]   <= avs_writedata[`MIC_C1_SER_EN];
                        irq_enable[`MIC_SRC_TICK0] <= avs_writedata[`MIC_C1_TICK0_EN];
                        irq_enable[`MIC_SRC_TICK1] <= avs_writedata[`MIC_C1_TICK1_EN];
                    end
                    // Enable mask of the level interrupt line
                    `MIC_ADDR_IRQ_EN: begin
                        evt_enable <= avs_writedata[6:0];
                    end
                    default: begin
                    end
                endcase
            end
            // Taking an interrupt: push, vector, clear flag and global
            if (take) begin
                taken_src <= mic_first(pending);
                global_irq_enable <= 1'b0;
                pc_value <= mic_vector(mic_first(pending));
                pc_load  <= 1'b1;
                ack      <= 1'b1;
            end
            // Pop: the read port shows the top entry one cycle on
            if (pop) begin
                state <= `MIC_ST_VEC;
            end else if (state == `MIC_ST_VEC) begin
                state    <= `MIC_ST_RUN;
                pc_value <= stk_rd;
                pc_load  <= 1'b1;
            end
            // Stack pointer bookkeeping
            if (push && !pop) begin
                sp <= sp + `MIC_SP_ONE;
            end else if (pop && !push) begin
                sp <= sp - `MIC_SP_ONE;
            end
            // Events set flags regardless of enables, set wins
            irq_flag   <= next_irq_flag;
            evt_status <= evt_status | src_event;
            // Write one to clear; an event in the same cycle wins
            if (wr && avs_address == `MIC_ADDR_CLEAR) begin
                evt_status <= (evt_status & ~avs_writedata[6:0]) | src_event;
            end
        end
    end

    // Read data path, one cycle after request
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_pend      <= 1'b0;
            avs_readdata <= 32'h00000000;
        end else begin
            rd_pend <= avs_read & ~rd_pend;
            if (avs_read && !rd_pend) begin
                case (avs_address)
                    `MIC_ADDR_EDGE:
                        avs_readdata <= {30'h0, ext_edge_select_field};
                    `MIC_ADDR_CTRL0:
                        avs_readdata <= {25'h0, irq_flag[`MIC_SRC_CMPP],
                            irq_flag[`MIC_SRC_CONV], irq_flag[`MIC_SRC_EXT],
                            irq_enable[`MIC_SRC_CMPP],
                            irq_enable[`MIC_SRC_CONV],
                            irq_enable[`MIC_SRC_EXT],
                            global_irq_enable};
                    `MIC_ADDR_CTRL1:
                        avs_readdata <= {24'h0, irq_flag[6:3],
                            irq_enable[6:3]};
                    `MIC_ADDR_STATUS:
                        avs_readdata <= {25'h0, evt_status};
                    `MIC_ADDR_IRQ_EN:
                        avs_readdata <= {25'h0, evt_enable};
                    default:
                        avs_readdata <= {28'h0, sp};
                endcase
            end
        end
    end

endmodule

/* File: logic/mic_defines.vh */
// Constants for the microcontroller interrupt controller
`ifndef MIC_DEFINES_VH
`define MIC_DEFINES_VH

// Register byte addresses on the Avalon-MM slave
`define MIC_ADDR_EDGE      4'h0
`define MIC_ADDR_CTRL0     4'h4
`define MIC_ADDR_CTRL1     4'h8
`define MIC_ADDR_STATUS    4'hC
`define MIC_ADDR_CLEAR     4'h1
`define MIC_ADDR_IRQ_EN    4'h5
`define MIC_ADDR_STACK     4'h9
`define MIC_ADDR_PCTRL     4'hC
`define MIC_PAGE_BIT       4

// Primary control register fields
`define MIC_C0_GIE         0
`define MIC_C0_EXT_EN      1
`define MIC_C0_CONV_EN     2
`define MIC_C0_CMPP_EN     3
`define MIC_C0_EXT_F       4
`define MIC_C0_CONV_F      5
`define MIC_C0_CMPP_F      6

// Secondary control register fields
`define MIC_C1_CMPA_EN     0
`define MIC_C1_SER_EN      1
`define MIC_C1_TICK0_EN    2
`define MIC_C1_TICK1_EN    3
`define MIC_C1_CMPA_F      4
`define MIC_C1_SER_F       5
`define MIC_C1_TICK0_F     6
`define MIC_C1_TICK1_F     7

// Edge select encodings
`define MIC_EDGE_OFF       2'h0
`define MIC_EDGE_RISE      2'h1
`define MIC_EDGE_FALL      2'h2
`define MIC_EDGE_BOTH      2'h3

// Source indices in priority order, index 0 wins
`define MIC_NSRC           7
`define MIC_SRC_EXT        0
`define MIC_SRC_CMPP       1
`define MIC_SRC_CONV       2
`define MIC_SRC_CMPA       3
`define MIC_SRC_SER        4
`define MIC_SRC_TICK0      5
`define MIC_SRC_TICK1      6

// Vector addresses, one per source
`define MIC_VEC_EXT        12'h004
`define MIC_VEC_CMPP       12'h008
`define MIC_VEC_CONV       12'h00C
`define MIC_VEC_CMPA       12'h010
`define MIC_VEC_SER        12'h014
`define MIC_VEC_TICK0      12'h018
`define MIC_VEC_TICK1      12'h01C

// Program counter and stack geometry
`define MIC_PC_W           12
`define MIC_STK_DEPTH      8
`define MIC_SP_W           4
`define MIC_SP_FULL        4'h8
`define MIC_SP_ZERO        4'h0
`define MIC_SP_ONE         4'h1

// Controller states
`define MIC_ST_RUN         1'b0
`define MIC_ST_VEC         1'b1

`endif

/* File: logic/mic_stack_mem.v */
// Return-address stack memory with registered read data
`timescale 1ns/1ps

module mic_stack_mem (
    input  wire        clock,
    input  wire        wr_en,
    input  wire [2:0]  wr_addr,
    input  wire [11:0] wr_data,
    input  wire [2:0]  rd_addr,
    output reg  [11:0] rd_data
);

    // Storage, no reset: contents are undefined until pushed
    reg [11:0] mem [0:7];

    // Write port and registered read port
    always @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end

endmodule

/* File: tb/mic_core_model.sv */
// Core sequencer model that answers vector loads and paces boundaries
`timescale 1ns/1ps

module mic_core_model (
    input  wire        clock,
    input  wire        nrst,
    input  wire        slow,
    input  wire        pc_load,
    input  wire [11:0] pc_value,
    output reg         instr_boundary,
    output wire [11:0] next_pc
);
    reg [11:0] pc;     // Current fetch address
    reg [1:0]  phase;  // Spacing of boundaries in slow mode

    // Held fetch address keeps the pushed value predictable
    assign next_pc = pc + 12'h001;

    // Slow mode offers a boundary only one cycle in four
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pc             <= 12'h100;
            phase          <= 2'h0;
            instr_boundary <= 1'b0;
        end else begin
            phase          <= phase + 2'h1;
            instr_boundary <= !slow || (phase == 2'h3);
            if (pc_load) begin
                pc <= pc_value;
            end
        end
    end
endmodule

/* File: tb/mic_irq_ctrl_asserts.sv */
// Port checker for the interrupt controller
`timescale 1ns/1ps

module mic_irq_chk (
    input wire        clock,
    input wire        nrst,
    input wire        avs_read,
    input wire        avs_write,
    input wire        avs_waitrequest,
    input wire        instr_boundary,
    input wire        return_from_irq,
    input wire        conv_event,
    input wire        serial_event,
    input wire        pc_load,
    input wire [11:0] pc_value,
    input wire        wake,
    input wire        stack_full
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    on_boundary_a: assert property (pc_load |->
        $past(instr_boundary) || $past(return_from_irq, 2))
        else $error("load without boundary");
    full_block_a: assert property (stack_full && !return_from_irq &&
        !$past(return_from_irq) |=> !pc_load)
        else $error("take while stack full");
    flag_wake_a: assert property ((conv_event || serial_event)
        |=> wake) else $error("event did not wake");
    ret_pop_a: assert property (return_from_irq |-> ##2 pc_load)
        else $error("return gave no load");
    no_nest_a: assert property (pc_load && !avs_write &&
        !return_from_irq && !$past(return_from_irq, 2) ##1
        (!avs_write && !return_from_irq) |=> !pc_load)
        else $error("nested take");
    vec_form_a: assert property (pc_load &&
        !$past(return_from_irq, 2) |-> pc_value[11:5] == 7'h00 &&
        pc_value[1:0] == 2'h0 && pc_value[4:2] != 3'h0)
        else $error("bad vector");
    rd_wait_a: assert property ($rose(avs_read) |->
        avs_waitrequest ##1 !avs_waitrequest) else $error("read wait");
    wr_wait_a: assert property (avs_write |-> !avs_waitrequest)
        else $error("write wait");
endmodule

bind mic_irq_ctrl mic_irq_chk u_chk (.clock(clock), .nrst(nrst),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .instr_boundary(instr_boundary),
    .return_from_irq(return_from_irq), .conv_event(conv_event),
    .serial_event(serial_event), .pc_load(pc_load),
    .pc_value(pc_value), .wake(wake), .stack_full(stack_full));

/* File: tb/tb.sv */
// Self-checking bench for the interrupt controller
`timescale 1ns/1ps
`include "mic_defines.vh"

module tb;
    localparam [3:0] ae = `MIC_ADDR_EDGE;
    localparam [3:0] a0 = `MIC_ADDR_CTRL0;
    localparam [3:0] a1 = `MIC_ADDR_CTRL1;
    reg         clock = 1'b0;
    reg         nrst = 1'b0;
    reg  [3:0]  adr = 4'h0;
    reg         rd = 1'b0;
    reg         wr = 1'b0;
    reg  [7:0]  wd = 8'h00;
    reg  [3:0]  be = 4'hF;
    reg         pin = 1'b0;
    reg  [6:0]  ev = 7'h00;   // Event pulses, index in priority order
    reg         ret = 1'b0;
    reg         push = 1'b0;
    reg         slow = 1'b0;
    reg  [7:0]  got;          // Last read byte
    reg  [11:0] lpc;          // Last loaded address
    wire [31:0] rdat;
    wire [11:0] pcv, npc;
    wire        wreq, ld, wake, full, irq, bnd;
    integer     num_errors = 0;
    integer     n_compared = 0;
    integer     n_ld = 0;     // Loads seen, so no pulse is missed
    reg  [11:0] vt [0:6] = '{`MIC_VEC_EXT, `MIC_VEC_CMPP, `MIC_VEC_CONV,
        `MIC_VEC_CMPA, `MIC_VEC_SER, `MIC_VEC_TICK0, `MIC_VEC_TICK1};
    reg  [3:0]  fp [0:6] = '{4'h4, 4'h6, 4'h5, 4'hC, 4'hD, 4'hE, 4'hF};

    always #4 clock = ~clock;
    // Count every load of the program counter
    always @(posedge clock) if (ld) begin
        n_ld <= n_ld + 1;
        lpc <= pcv;
    end

    mic_irq_ctrl dut (.clock(clock), .nrst(nrst), .avs_address(adr),
        .avs_read(rd), .avs_write(wr), .avs_writedata({24'h0, wd}),
        .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wreq),
        .ext_pin(pin), .conv_event(ev[2]), .cmp_p_event(ev[1]),
        .cmp_a_event(ev[3]), .serial_event(ev[4]), .tick0_event(ev[5]),
        .tick1_event(ev[6]), .instr_boundary(bnd), .next_pc(npc),
        .return_from_irq(ret), .push_call(push), .pc_load(ld),
        .pc_value(pcv), .wake(wake), .stack_full(full), .irq(irq));
    mic_core_model u_core (.clock(clock), .nrst(nrst), .slow(slow),
        .pc_load(ld), .pc_value(pcv), .instr_boundary(bnd), .next_pc(npc));

    task report_and_stop;
        begin
            $display("compared %0d mismatches %0d", n_compared, num_errors);
            if (num_errors == 0 && n_compared > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    task tally(input ok, input [11:0] g, input [11:0] e);
        begin
            n_compared = n_compared + 1;
            if (!ok) begin
                num_errors = num_errors + 1;
                $display("[FAIL] %0t got %h exp %h", $time, g, e);
            end
        end
    endtask
    task chk_reg(input [7:0] g, input [7:0] e);
        tally(g === e, {4'h0, g}, {4'h0, e});
    endtask
    task chk_pc(input [11:0] g, input [11:0] e);
        tally(g === e, g, e);
    endtask
    task chk_bit(input g, input e);
        tally(g === e, {11'h0, g}, {11'h0, e});
    endtask
    // One bus cycle, held until waitrequest is seen low
    task bus(input w, input [3:0] a, input [7:0] d);
        integer n;
        begin
            adr <= a; wd <= d; wr <= w; rd <= !w;
            n = 0;
            @(posedge clock);
            while (wreq !== 1'b0) begin
                n = n + 1;
                if (n > 20) begin
                    num_errors = num_errors + 1;
                    report_and_stop;
                end
                @(posedge clock);
            end
            got = rdat[7:0];
            wr <= 1'b0; rd <= 1'b0;
            @(posedge clock);
        end
    endtask
    task pulse(input [6:0] m, input r, input p);
        begin
            ev <= m; ret <= r; push <= p;
            @(posedge clock);
            ev <= 7'h00; ret <= 1'b0; push <= 1'b0;
            @(posedge clock);
        end
    endtask
    task wait_ld(input integer t);
        integer k;
        begin
            k = 0;
            while (n_ld < t) begin
                k = k + 1;
                if (k > 60) begin
                    num_errors = num_errors + 1;
                    report_and_stop;
                end
                @(posedge clock);
            end
        end
    endtask

    task t_regs;
        begin
            chk_bit(irq, 1'b0);
            bus(0, ae, 0); chk_reg(got, 8'h00);
            bus(0, a0, 0); chk_reg(got, 8'h00);
            bus(0, a1, 0); chk_reg(got, 8'h00);
            bus(1, a0, 8'h80); bus(0, a0, 0); chk_reg(got, 8'h00);
            bus(1, ae, 8'hFF); bus(1, 4'h2, 8'h00);
            be <= 4'h0; bus(1, ae, 8'h00); be <= 4'hF;
            bus(0, ae, 0); chk_reg(got, 8'h03);
            $display("regs test done");
        end
    endtask
    // Sticky status, enable mask and write-one-to-clear on the level line
    task t_irq;
        begin
            bus(1, `MIC_ADDR_CLEAR, 8'h7F); bus(1, `MIC_ADDR_IRQ_EN, 8'h04);
            bus(0, `MIC_ADDR_STATUS, 0); chk_reg(got, 8'h00);
            chk_bit(irq, 1'b0);
            pulse(7'h02, 0, 0); chk_bit(irq, 1'b0);  // Masked source
            pulse(7'h04, 0, 0); chk_bit(irq, 1'b1);
            bus(0, `MIC_ADDR_STATUS, 0); chk_reg(got, 8'h06);
            bus(0, `MIC_ADDR_IRQ_EN, 0); chk_reg(got, 8'h04);
            bus(1, `MIC_ADDR_CLEAR, 8'h04); chk_bit(irq, 1'b0);
            bus(1, a0, 0); bus(1, a1, 0);
            $display("irq test done");
        end
    endtask
    // Each edge mode against one rising and one falling pin edge
    task t_edge;
        integer m;
        for (m = 0; m < 4; m = m + 1) begin
            bus(1, ae, m[7:0]); pin <= 1'b1; repeat (5) @(posedge clock);
            bus(0, a0, 0); chk_reg(got, {3'h0, m[0], 4'h0});
            bus(1, a0, 0); pin <= 1'b0; repeat (5) @(posedge clock);
            bus(0, a0, 0); chk_reg(got, {3'h0, m[1], 4'h0});
            bus(1, a0, 0);
            if (m == 3) $display("edge test done");
        end
    endtask
    // All sources pending at once, served one by one
    task t_prio;
        integer i, n0;
        reg [15:0] fl;
        reg [11:0] sv;
        begin
            bus(1, ae, 8'h01); n0 = n_ld;
            pulse(7'h7E, 0, 0); pin <= 1'b1; repeat (5) @(posedge clock);
            bus(0, a0, 0); chk_reg(got, 8'h70);
            bus(0, a1, 0); chk_reg(got, 8'hF0);
            chk_bit(wake, 1'b1);
            bus(1, a0, 8'h7E); bus(1, a1, 8'hFF); repeat (8) @(posedge clock);
            chk_bit(n_ld == n0, 1'b1);
            fl = 16'hFF7E;
            for (i = 0; i < 7; i = i + 1) begin
                sv = npc; n0 = n_ld;
                bus(1, a0, fl[7:0] | 8'h01);
                wait_ld(n0 + 1); chk_pc(lpc, vt[i]);
                fl[fp[i]] = 1'b0;
                bus(0, a0, 0); chk_reg(got, fl[7:0]);
                bus(0, a1, 0); chk_reg(got, fl[15:8]);
                n0 = n_ld; pulse(0, 1, 0);
                wait_ld(n0 + 1); chk_pc(lpc, sv);
            end
            chk_bit(wake, 1'b0);
            $display("priority test done");
        end
    endtask
    // Full stack holds off the take until one return
    task t_full;
        integer k, n0;
        begin
            slow <= 1'b1;
            for (k = 0; k < 8; k = k + 1) pulse(0, 0, 1);
            chk_bit(full, 1'b1);
            pulse(7'h04, 0, 0); bus(1, a0, 8'h25); n0 = n_ld;
            repeat (10) @(posedge clock);
            chk_bit(n_ld == n0, 1'b1);
            pulse(0, 1, 0); wait_ld(n0 + 2);
            chk_pc(lpc, `MIC_VEC_CONV);
            chk_bit(full, 1'b1);
            slow <= 1'b0;
            $display("stack test done");
        end
    endtask

    initial begin
        repeat (16) @(posedge clock);
        nrst <= 1'b1;
        repeat (4) @(posedge clock);
        t_regs;
        t_irq;
        t_edge;
        t_prio;
        t_full;
        report_and_stop;
    end
    // Hang guard
    initial begin
        repeat (20000) @(posedge clock);
        num_errors = num_errors + 1;
        report_and_stop;
    end
endmodule
